// ===== inc/shr_pkg.sv
// Constants, codes and register map of the setpoint relay and recorder block.
// Assumes an APB master on a 25 MHz clock and same-clock pressure words.
package shr_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int STATION_COUNT = 10;
    localparam int RELAY_COUNT = 4;
    localparam int PRESSURE_W = 32;
    localparam int RECORDER_W = 16;
    localparam int ADDR_W = 8;
    localparam int TYPE_W = 3;
    localparam int FMT_W = 2;
    localparam int STATION_W = 4;
    localparam int UNITS_W = 3;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_FORMAT = 8'h00;
    localparam logic [7:0] ADDR_INSTALLED = 8'h04;
    localparam logic [7:0] ADDR_SENSOR_TYPE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_DISPLAY_UNITS = 8'h10;
    localparam logic [3:0] RELAY_BLOCK_FIRST = 4'h2;
    localparam logic [3:0] RELAY_BLOCK_LAST = 4'h5;
    localparam logic [1:0] FIELD_ON_SETPOINT = 2'h0;
    localparam logic [1:0] FIELD_OFF_SETPOINT = 2'h1;
    localparam logic [1:0] FIELD_STATION = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [19:0] FORMAT_RESET = 20'h00000;
    localparam logic [9:0] INSTALLED_RESET = 10'h3ff;
    localparam logic [29:0] SENSOR_TYPE_RESET = 30'h00000000;
    localparam logic [2:0] DISPLAY_UNITS_RESET = 3'h0;
    localparam logic [31:0] SETPOINT_ON_RESET = 32'h00000000;
    localparam logic [31:0] SETPOINT_OFF_RESET = 32'h00000000;
    localparam logic [3:0] STATION_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Sensor types and recorder formats
    // ----------------------------------------------------------------
    localparam logic [2:0] SENSOR_THERMOCOUPLE = 3'h0;
    localparam logic [2:0] SENSOR_CONVECTION = 3'h1;
    localparam logic [2:0] SENSOR_DIAPHRAGM = 3'h2;
    localparam logic [2:0] SENSOR_COLD_CATHODE = 3'h3;
    localparam logic [2:0] SENSOR_HOT_CATHODE = 3'h4;

    typedef enum logic [1:0] {
        FMT_LINEAR_PER_DECADE = 2'h0,
        FMT_LINEAR_MICRON_SCALE = 2'h1,
        FMT_LINEAR_TORR_SCALE = 2'h2,
        FMT_LOGARITHMIC = 2'h3
    } shr_fmt_t;

    // ----------------------------------------------------------------
    // Pressure code: [31:24] decade exponent biased by 0x80, [23:0] mantissa
    // 100000..999999 for 1.00000..9.99999; larger code means higher pressure
    // ----------------------------------------------------------------
    localparam logic [7:0] DECADE_BIAS = 8'h80;
    localparam logic [31:0] PRESSURE_ZERO = 32'h00000000;
    localparam logic [31:0] PRESSURE_ONE_MICRON = 32'h7d0186a0;
    localparam logic [31:0] PRESSURE_TEN_MILLITORR = 32'h7e0186a0;
    localparam logic [31:0] PRESSURE_ONE_TORR = 32'h800186a0;
    localparam logic [31:0] PRESSURE_THREE_TORR = 32'h800493e0;
    localparam logic [31:0] PRESSURE_990_TORR = 32'h820f1b30;

    // ----------------------------------------------------------------
    // Recorder scaling in millivolts
    // ----------------------------------------------------------------
    localparam int MANTISSA_UNIT = 100000;
    localparam int PER_DECADE_OFFSET = 7;
    localparam int PER_DECADE_MV = 1000;
    localparam int PER_DECADE_FLOOR_MV = 4000;
    localparam int MICRON_SCALE_SHIFT = 1;
    localparam int TORR_SCALE_SHIFT = 2;
    localparam int LOG_DECADE_MV = 1667;
    localparam int LOG_OFFSET = 3;
    localparam int RECORDER_FULL_MV = 10000;
    localparam int RECORDER_LINEAR_MAX_MV = 13500;
    localparam int LOG_DIGIT_MV [10] = '{0, 0, 502, 795, 1003, 1165, 1297, 1409, 1505, 1591};

endpackage

// ===== hdl/shr_setpoint_relay.sv
// Setpoint relay controller with hysteresis and per-station recorder outputs.
// Assumes an APB master on clock and station pressure words from same-clock logic.
//
// Operation
// - Four relays, each with on/off setpoints
// - Each relay compares one selectable station
// - Energize when pressure below on setpoint
// - De-energize when pressure above off setpoint
// - Between setpoints relay keeps its state
// - One indicator per relay, lit when energized
// - Setpoints limited by sensor type ranges
// - Recorder output for every installed station
// - Recorder uses sensor native units only
// - Display units never change recorder scaling
// - Recorder format chosen by serial codes
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

module shr_setpoint_relay
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Station pressure words, station n at bits [32n+31:32n]
    input wire logic [319:0] stationPressure,
    // Relay drives and front panel indicators
    output logic [3:0] relayOut,
    output logic [3:0] relayLed,
    // Recorder levels in millivolts, station n at bits [16n+15:16n]
    output logic [159:0] recorderOut,
    // Units chosen for the front display
    output logic [2:0] displayUnits
);

    // ----------------------------------------------------------------
    // Conversion helpers
    // ----------------------------------------------------------------

    // Decimal shift of a mantissa: negative k divides, positive k saturates
    function automatic int scaleDecimal(input int m, input int k);
        int r;
        r = (k > 0) ? 32'h3fffffff : m;
        for (int i = 0; i < 9; i++)
            if (k <= 0 && i < -k)
                r = r / 10;
        return r;
    endfunction

    // Pressure code to recorder millivolts in the sensor's own units
    function automatic logic [15:0] recorderConvert(input logic [31:0] p, input logic [1:0] fmt);
        int d;
        int m;
        int digit;
        int mv;
        int cap;
        d = int'(p[31:24]) - int'(shr_pkg::DECADE_BIAS);
        m = int'(p[23:0]);
        digit = m / shr_pkg::MANTISSA_UNIT;
        mv = 0;
        if (digit > 9)
            digit = 9;
        unique case (shr_pkg::shr_fmt_t'(fmt))
            shr_pkg::FMT_LINEAR_PER_DECADE:
                mv = (p < shr_pkg::PRESSURE_ONE_MICRON) ? shr_pkg::PER_DECADE_FLOOR_MV
                    : (d + shr_pkg::PER_DECADE_OFFSET) * shr_pkg::PER_DECADE_MV + m / 1000;
            shr_pkg::FMT_LINEAR_MICRON_SCALE:
                mv = scaleDecimal(m, d - shr_pkg::MICRON_SCALE_SHIFT);
            shr_pkg::FMT_LINEAR_TORR_SCALE:
                mv = scaleDecimal(m, d - shr_pkg::TORR_SCALE_SHIFT);
            shr_pkg::FMT_LOGARITHMIC:
                mv = (p < shr_pkg::PRESSURE_ONE_MICRON) ? 0 : (d + shr_pkg::LOG_OFFSET)
                    * shr_pkg::LOG_DECADE_MV + shr_pkg::LOG_DIGIT_MV[digit];
        endcase
        // Micron and torr scale formats may run past full scale up to their own ceiling
        cap = (fmt == shr_pkg::FMT_LINEAR_MICRON_SCALE
            || fmt == shr_pkg::FMT_LINEAR_TORR_SCALE)
            ? shr_pkg::RECORDER_LINEAR_MAX_MV : shr_pkg::RECORDER_FULL_MV;
        if (mv > cap)
            mv = cap;
        return mv[15:0];
    endfunction

    // Range limit of a setpoint for the sensor type it is compared against
    function automatic logic [31:0] clampSetpoint(input logic [31:0] v, input logic [2:0] kind);
        logic [31:0] lo;
        logic [31:0] hi;
        lo = shr_pkg::PRESSURE_ZERO;
        hi = 32'hffffffff;
        if (kind == shr_pkg::SENSOR_COLD_CATHODE || kind == shr_pkg::SENSOR_HOT_CATHODE)
        begin
            hi = shr_pkg::PRESSURE_TEN_MILLITORR;
        end
        else if (kind == shr_pkg::SENSOR_CONVECTION)
        begin
            lo = shr_pkg::PRESSURE_ONE_MICRON;
            hi = shr_pkg::PRESSURE_990_TORR;
        end
        else if (kind == shr_pkg::SENSOR_DIAPHRAGM)
        begin
            lo = shr_pkg::PRESSURE_ONE_TORR;
            hi = shr_pkg::PRESSURE_990_TORR;
        end
        else if (kind == shr_pkg::SENSOR_THERMOCOUPLE)
        begin
            lo = shr_pkg::PRESSURE_ONE_MICRON;
            hi = shr_pkg::PRESSURE_THREE_TORR;
        end
        if (v < lo)
            return lo;
        if (v > hi)
            return hi;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [19:0] formatReg;
    logic [9:0] installedReg;
    logic [29:0] sensorTypeReg;
    logic [2:0] displayUnitsReg;
    logic [31:0] onSetpointReg [4];
    logic [31:0] offSetpointReg [4];
    logic [3:0] relayStationReg [4];
    logic [3:0] relayReg;
    logic [3:0] relayNext;
    logic [15:0] recorderReg [10];
    logic [3:0] scanReg;
    logic [31:0] prdataReg;
    logic slverrReg;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic setupPhase;
    wire logic writeAccess;
    wire logic hitFormat;
    wire logic hitInstalled;
    wire logic hitSensorType;
    wire logic hitStatus;
    wire logic hitUnits;
    wire logic relayHit;
    wire logic [1:0] relayIdx;
    wire logic [1:0] relayField;
    wire logic addrValid;
    wire logic [3:0] targetStation;
    wire logic [2:0] targetType;
    wire logic [31:0] clampedSetpoint;
    wire logic [31:0] readMux;

    // Phase strobes and register hits
    assign setupPhase = psel & ~penable;
    assign writeAccess = psel & penable & pwrite;
    assign hitFormat = paddr == shr_pkg::ADDR_FORMAT;
    assign hitInstalled = paddr == shr_pkg::ADDR_INSTALLED;
    assign hitSensorType = paddr == shr_pkg::ADDR_SENSOR_TYPE;
    assign hitStatus = paddr == shr_pkg::ADDR_STATUS;
    assign hitUnits = paddr == shr_pkg::ADDR_DISPLAY_UNITS;
    assign relayField = paddr[3:2];
    assign relayIdx = 2'(paddr[7:4] - shr_pkg::RELAY_BLOCK_FIRST);
    assign relayHit = paddr[7:4] >= shr_pkg::RELAY_BLOCK_FIRST
        && paddr[7:4] <= shr_pkg::RELAY_BLOCK_LAST
        && relayField != 2'h3 && paddr[1:0] == 2'h0;
    assign addrValid = hitFormat | hitInstalled | hitSensorType | hitStatus | hitUnits | relayHit;

    // Setpoint limit follows the type of the relay's assigned station
    assign targetStation = relayStationReg[relayIdx];
    assign targetType = sensorTypeReg[3 * targetStation +: 3];
    assign clampedSetpoint = clampSetpoint(pwdata, targetType);

    // Read data selection, zero for anything unmapped
    assign readMux = hitFormat ? {12'h0, formatReg}
        : hitInstalled ? {22'h0, installedReg}
        : hitSensorType ? {2'h0, sensorTypeReg}
        : hitStatus ? {28'h0, relayReg}
        : hitUnits ? {29'h0, displayUnitsReg}
        : !relayHit ? 32'h0
        : relayField == shr_pkg::FIELD_ON_SETPOINT ? onSetpointReg[relayIdx]
        : relayField == shr_pkg::FIELD_OFF_SETPOINT ? offSetpointReg[relayIdx]
        : {28'h0, relayStationReg[relayIdx]};

    // Answer captured in the setup cycle, presented in the access cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdataReg <= 32'h00000000;
            slverrReg <= 1'b0;
        end
        else if (setupPhase)
        begin
            prdataReg <= pwrite ? 32'h00000000 : readMux;
            slverrReg <= ~addrValid;
        end
    end

    assign prdata = prdataReg;
    assign pslverr = slverrReg & psel & penable;
    assign pready = 1'b1;

    // ----------------------------------------------------------------
    // Configuration writes
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            formatReg <= shr_pkg::FORMAT_RESET;
            installedReg <= shr_pkg::INSTALLED_RESET;
            sensorTypeReg <= shr_pkg::SENSOR_TYPE_RESET;
            displayUnitsReg <= shr_pkg::DISPLAY_UNITS_RESET;
            for (int r = 0; r < shr_pkg::RELAY_COUNT; r++)
            begin
                onSetpointReg[r] <= shr_pkg::SETPOINT_ON_RESET;
                offSetpointReg[r] <= shr_pkg::SETPOINT_OFF_RESET;
                relayStationReg[r] <= shr_pkg::STATION_RESET;
            end
        end
        else if (writeAccess && addrValid)
        begin
            if (hitFormat)
            begin
                formatReg <= pwdata[19:0];
            end
            if (hitInstalled)
            begin
                installedReg <= pwdata[9:0];
            end
            if (hitSensorType)
            begin
                sensorTypeReg <= pwdata[29:0];
            end
            if (hitUnits)
            begin
                displayUnitsReg <= pwdata[2:0];
            end
            if (relayHit && relayField == shr_pkg::FIELD_ON_SETPOINT)
            begin
                onSetpointReg[relayIdx] <= clampedSetpoint;
            end
            if (relayHit && relayField == shr_pkg::FIELD_OFF_SETPOINT)
            begin
                offSetpointReg[relayIdx] <= clampedSetpoint;
            end
            // Station numbers past the last station are ignored
            if (relayHit && relayField == shr_pkg::FIELD_STATION
                && pwdata[3:0] < 4'(shr_pkg::STATION_COUNT) && pwdata[31:4] == 28'h0000000)
            begin
                relayStationReg[relayIdx] <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Relay hysteresis
    // ----------------------------------------------------------------
    for (genvar r = 0; r < 4; r++)
    begin : gRelay
        wire logic [31:0] watched;
        wire logic belowOn;
        wire logic aboveOff;
        // Only the assigned station feeds this relay
        assign watched = stationPressure[32 * relayStationReg[r] +: 32];
        // Strict compares: equality stays inside the band
        assign belowOn = watched < onSetpointReg[r];
        assign aboveOff = watched > offSetpointReg[r];
        // Below on wins if the pair is entered upside down
        assign relayNext[r] = belowOn ? 1'b1 : (aboveOff ? 1'b0 : relayReg[r]);
    end

    // Relay state register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            relayReg <= 4'h0;
        end
        else
        begin
            relayReg <= relayNext;
        end
    end

    assign relayOut = relayReg;
    assign relayLed = relayReg;
    assign displayUnits = displayUnitsReg;

    // ----------------------------------------------------------------
    // Recorder outputs: one converter visits each station in turn
    // ----------------------------------------------------------------
    wire logic [31:0] scanPressure;
    wire logic [1:0] scanFormat;
    wire logic [15:0] scanLevel;

    // Conversion ignores the display units entirely
    assign scanPressure = stationPressure[32 * scanReg +: 32];
    assign scanFormat = formatReg[2 * scanReg +: 2];
    assign scanLevel = recorderConvert(scanPressure, scanFormat);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            scanReg <= 4'h0;
            for (int s = 0; s < shr_pkg::STATION_COUNT; s++)
            begin
                recorderReg[s] <= 16'h0000;
            end
        end
        else
        begin
            scanReg <= (scanReg == 4'(shr_pkg::STATION_COUNT - 1)) ? 4'h0 : scanReg + 4'h1;
            recorderReg[scanReg] <= installedReg[scanReg] ? scanLevel : 16'h0000;
        end
    end

    // Flatten recorder levels onto the output bus
    for (genvar s = 0; s < 10; s++)
    begin : gRecorder
        assign recorderOut[16 * s +: 16] = recorderReg[s];
    end

endmodule

// ===== verif/shr_setpoint_relay_sva.sv
// Port checker for the setpoint relay block.
// Assumes a bind to shr_setpoint_relay; sees only its ports.
`timescale 1ns/10ps
module shr_setpoint_relay_sva
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Plant side
    input wire logic [319:0] stationPressure,
    input wire logic [3:0] relayOut,
    input wire logic [3:0] relayLed,
    input wire logic [159:0] recorderOut,
    input wire logic [2:0] displayUnits
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    logic [319:0] prevP_reg;
    logic wrAny;
    logic recOver;
    // Display unit writes must not restart the quiet count
    assign wrAny = psel && penable && pwrite;
    assign quiet_next = ((wrAny && paddr != shr_pkg::ADDR_DISPLAY_UNITS) ||
        stationPressure != prevP_reg) ? 4'h0 : (quiet_reg == 4'hf ? 4'hf : quiet_reg + 4'h1);
    // Count of cycles with steady recorder inputs
    always_ff @(posedge clock)
    begin
        prevP_reg <= stationPressure;
        quiet_reg <= rst_n ? quiet_next : 4'h0;
    end
    // Any recorder field above the linear ceiling
    always_comb
    begin
        recOver = 1'b0;
        for (int i = 0; i < 10; i++)
            recOver = recOver | (recorderOut[16*i +: 16] > 16'h34bc);
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_write;
        psel && penable && pwrite;
    endsequence
    a_led_follow: assert property (relayLed == relayOut)
        else $error("indicator differs from relay drive");
    a_relay_hold: assert property (
        $stable(stationPressure) && !$past(wrAny) |=> $stable(relayOut))
        else $error("relay moved with steady pressure and setpoints");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_err_data: assert property (s_access ##0 pslverr |-> prdata == 32'h0)
        else $error("read data not zero on slave error");
    a_ready_zero_wait: assert property (s_access |-> pready)
        else $error("access phase stalled");
    a_write_rdzero: assert property (s_write |-> prdata == 32'h0)
        else $error("read data not zero during write");
    a_rec_quiet: assert property (quiet_reg >= 4'hc |-> $stable(recorderOut))
        else $error("recorder moved with steady inputs");
    a_rec_ceiling: assert property (!recOver)
        else $error("recorder level above ceiling");
    a_units_written: assert property ($past(rst_n) && !$past(wrAny) |-> $stable(displayUnits))
        else $error("display units changed without a write");
endmodule

bind shr_setpoint_relay shr_setpoint_relay_sva i_shr_setpoint_relay_sva
(
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stationPressure(stationPressure), .relayOut(relayOut), .relayLed(relayLed),
    .recorderOut(recorderOut), .displayUnits(displayUnits)
);

// ===== verif/shr_plant_model.sv
// Gauge stations and relay-driven valves around the relay block.
// Assumes the bench sets target pressures at rising edges.
`timescale 1ns/10ps
module shr_plant_model
(
    // Clock
    input wire logic clock,
    // Bench targets and relay drives
    input wire logic [319:0] targetPressure,
    input wire logic [3:0] relayOut,
    // Gauge readings and valve states
    output logic [319:0] stationPressure,
    output logic [3:0] valveOpen
);
    // Gauges report one cycle late, valves follow the relays
    always_ff @(posedge clock)
    begin
        stationPressure <= targetPressure;
        valveOpen <= relayOut;
    end
endmodule

// ===== verif/shr_setpoint_relay_tb.sv
// Self-checking bench for the setpoint relay block.
// Assumes the plant model and the bound port checker.
`timescale 1ns/10ps
module shr_setpoint_relay_tb;
    // ----------------------------------------------------------------
    // Signals and tables
    // ----------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [319:0] targetP = {10{32'h8007a120}};
    logic [319:0] stationPressure;
    logic [3:0] relayOut;
    logic [3:0] relayLed;
    logic [159:0] recorderOut;
    logic [2:0] displayUnits;
    int errCount = 0;
    int checksDone = 0;
    logic [31:0] hp [9] = '{32'h8007a120, 32'h7f07a120, 32'h800186a0, 32'h80030d40,
        32'h800493e0, 32'h80061a80, 32'h80030d40, 32'h800186a0, 32'h7f07a120};
    logic [3:0] hr [9] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h1};
    logic [2:0] ct [7] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [31:0] cw [7] = '{32'h820f1b30, 32'h0, 32'h830186a0, 32'h800186a0, 32'h7d0186a0,
        32'h800186a0, 32'h800186a0};
    logic [31:0] ce [7] = '{32'h800493e0, 32'h7d0186a0, 32'h820f1b30, 32'h800186a0,
        32'h800186a0, 32'h7e0186a0, 32'h7e0186a0};
    logic [15:0] re [4] = '{16'h1bbc, 16'h2710, 16'h03e8, 16'h1389};

    // Clock at 25 MHz
    always #20 clock = ~clock;

    // Device and plant
    shr_setpoint_relay i_shr_setpoint_relay (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stationPressure(stationPressure),
        .relayOut(relayOut), .relayLed(relayLed), .recorderOut(recorderOut),
        .displayUnits(displayUnits));
    shr_plant_model i_shr_plant_model (.clock(clock), .targetPressure(targetP),
        .relayOut(relayOut), .stationPressure(stationPressure), .valveOpen());

    // ----------------------------------------------------------------
    // Bus, wait and compare tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmpRelay(input string nm, input logic [3:0] e, input logic [3:0] g);
        checksDone++;
        if (g !== e)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        cmpWord(nm, e, rd);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic tReset;
        logic [31:0] rd;
        logic er;
        rdChk("format", shr_pkg::ADDR_FORMAT, 32'h0);
        rdChk("installed", shr_pkg::ADDR_INSTALLED, 32'h3ff);
        rdChk("sensor type", shr_pkg::ADDR_SENSOR_TYPE, 32'h0);
        rdChk("on setpoint", 8'h20, 32'h0);
        wr(shr_pkg::ADDR_STATUS, 32'hf);
        rdChk("status", shr_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, 8'hfc, 32'h0, rd, er);
        cmpWord("unmapped error", 32'h1, {31'h0, er});
        cmpWord("unmapped data", 32'h0, rd);
        $display("tReset done");
    endtask
    task automatic tHysteresis;
        wr(shr_pkg::ADDR_SENSOR_TYPE, 32'h8);
        wr(8'h28, 32'h1);
        wr(8'h20, shr_pkg::PRESSURE_ONE_TORR);
        wr(8'h24, shr_pkg::PRESSURE_THREE_TORR);
        targetP[31:0] <= shr_pkg::PRESSURE_ZERO;
        for (int i = 0; i < 9; i++)
        begin
            targetP[63:32] <= hp[i];
            settle(4);
            cmpRelay("relay drive", hr[i], relayOut);
            cmpRelay("indicator", hr[i], relayLed);
        end
        rdChk("status", shr_pkg::ADDR_STATUS, 32'h1);
        $display("tHysteresis done");
    endtask
    task automatic tClamp;
        for (int i = 0; i < 7; i++)
        begin
            wr(shr_pkg::ADDR_SENSOR_TYPE, {23'h0, ct[i], 6'h0});
            wr(8'h38, 32'h2);
            wr(8'h30, cw[i]);
            rdChk("clamped setpoint", 8'h30, ce[i]);
        end
        wr(8'h38, 32'hc);
        rdChk("station select", 8'h38, 32'h2);
        $display("tClamp done");
    endtask
    task automatic tRecorder;
        targetP[191:160] <= shr_pkg::PRESSURE_ONE_TORR;
        for (int c = 0; c < 4; c++)
        begin
            wr(shr_pkg::ADDR_FORMAT, 32'(c) << 10);
            settle(12);
            cmpWord("recorder", {16'h0, re[c]}, {16'h0, recorderOut[95:80]});
        end
        wr(shr_pkg::ADDR_DISPLAY_UNITS, 32'h3);
        settle(12);
        cmpWord("recorder", {16'h0, re[3]}, {16'h0, recorderOut[95:80]});
        rdChk("units", shr_pkg::ADDR_DISPLAY_UNITS, 32'h3);
        cmpWord("units pin", 32'h3, {29'h0, displayUnits});
        wr(shr_pkg::ADDR_INSTALLED, 32'h3df);
        settle(12);
        cmpWord("absent station", 32'h0, {16'h0, recorderOut[95:80]});
        cmpWord("present station", 32'h1d4c, {16'h0, recorderOut[79:64]});
        $display("tRecorder done");
    endtask

    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        tReset;
        tHysteresis;
        tClamp;
        tRecorder;
        reportAndStop;
    end
    initial
    begin
        repeat (6000) @(posedge clock);
        errCount++;
        $display("[ERR] watchdog expected end seen hang");
        reportAndStop;
    end
endmodule
